//--- src/monitor_pins_pkg.sv
// Constants, register map and types for the reset, test and voltage-ID pins.
// Assumes a single 125 MHz clock and an AHB-Lite register port.
//
// Functional notes
// - A high test-enable pin puts the device into NAND tree test mode.
// - Outside NAND tree test the shared pin serves as analog output.
// - Config bit 4 drives the open-drain reset pin low for at least 45 ms.
// - An outside low on the reset pin acts as a device reset.
// - An outside low on the reset pin returns every software register to its default.
// - Voltage-ID bit 4 is captured into its own status register.
// - Voltage-ID bits 3 to 0 are captured together into one register.
// - Each voltage-ID pin may be switched to act as an interrupt input.
package monitor_pins_pkg;

  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned RST_PULSE_MS = 45;
  localparam int unsigned RST_PULSE_CYC_DEF =
    RST_PULSE_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 23;

  localparam int VID_N = 5;
  localparam int ST_W  = 6;
  localparam int CFG_W = 8;

  localparam logic [7:0] A_VID_LOW  = 8'h00;
  localparam logic [7:0] A_VID4     = 8'h04;
  localparam logic [7:0] A_IRQ_MODE = 8'h08;
  localparam logic [7:0] A_STATUS   = 8'h0c;
  localparam logic [7:0] A_MASK     = 8'h10;
  localparam logic [7:0] A_PINS     = 8'h14;
  localparam logic [7:0] A_CONFIG   = 8'h40;

  localparam int CFG_PULSE_BIT = 4;
  localparam int EV_PULSE_DONE = 5;
  localparam int PS_TEST = 0;
  localparam int PS_PIN  = 1;
  localparam int PS_BUSY = 2;

  localparam logic [CFG_W-1:0] CFG_RST      = 8'h00;
  localparam logic [ST_W-1:0]  MASK_RST     = 6'h00;
  localparam logic [VID_N-1:0] IRQ_MODE_RST = 5'h00;
  localparam logic [1:0]       BLANK_CYC    = 2'h3;

  typedef enum logic [1:0] {
    RP_IDLE  = 2'b00,
    RP_DRIVE = 2'b01,
    RP_BLANK = 2'b11
  } rst_pin_state_t;

endpackage

//--- src/pulse_if.sv
// Handshake between the reset pin controller and its pulse timer.
// Both ends run on the same clock.
`timescale 1ns/1ps
interface pulse_if;
  logic start;
  logic busy;
  logic done;
  modport ctrl  (output start, input busy, input done);
  modport timer (input start, output busy, output done);
endinterface

//--- src/pulse_timer.sv
// Counter that times the reset pin pulse.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
module pulse_timer #(
  parameter int unsigned CYC = monitor_pins_pkg::RST_PULSE_CYC_DEF
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  pulse_if.timer    tif
);
  import monitor_pins_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic             busy_r;
  logic             done_r;
  logic             last;

  assign last     = (cnt_r == CNT_W'(CYC - 1));
  assign tif.busy = busy_r;
  assign tif.done = done_r;

  // Busy stands for exactly CYC cycles; done follows as a pulse.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (!busy_r) begin
        if (tif.start) begin
          busy_r <= 1'b1;
          cnt_r  <= '0;
        end
      end else if (last) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  property p_busy_len;
    @(posedge hclk) disable iff (!hresetn)
    $fell(busy_r) |-> $past(cnt_r) == CNT_W'(CYC - 1) && done_r;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("Pulse timer ended early or late.");

endmodule

//--- src/monitor_pins.sv
// Pin logic of the hardware monitor: reset pin, test enable, voltage-ID.
// Assumes an AHB-Lite master on hclk; all pins are asynchronous to it.
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module monitor_pins #(
  parameter int unsigned RST_PULSE_CYC =
    monitor_pins_pkg::RST_PULSE_CYC_DEF
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        test_enable_or_analog_out,
  output logic             analog_out_en,
  output logic             nand_test_mode,
  output logic             nand_tree_out,
  input  wire logic        reset_pin_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe,
  input  wire logic        voltage_id_bit4_or_irq,
  input  wire logic        voltage_id_bit3_or_irq,
  input  wire logic        voltage_id_bit2_or_irq,
  input  wire logic        voltage_id_bit1_or_irq,
  input  wire logic        voltage_id_bit0_or_irq,
  output logic             irq
);
  import monitor_pins_pkg::*;

  pulse_if tif ();

  pulse_timer #(
    .CYC (RST_PULSE_CYC)
  ) u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tif     (tif)
  );

  // Pin synchronisers.

  logic [VID_N-1:0] vid_pin;
  logic [VID_N-1:0] vid_s1_r;
  logic [VID_N-1:0] vid_s2_r;
  logic [VID_N-1:0] vid_d_r;
  logic             test_s1_r;
  logic             test_s2_r;
  logic             rpin_s1_r;
  logic             rpin_s2_r;

  assign vid_pin = {voltage_id_bit4_or_irq, voltage_id_bit3_or_irq,
                    voltage_id_bit2_or_irq, voltage_id_bit1_or_irq,
                    voltage_id_bit0_or_irq};

  // The VID and reset pins idle high through their pull-ups; test enable idles low.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vid_s1_r  <= '1;
      vid_s2_r  <= '1;
      vid_d_r   <= '1;
      test_s1_r <= 1'b0;
      test_s2_r <= 1'b0;
      rpin_s1_r <= 1'b1;
      rpin_s2_r <= 1'b1;
    end else begin
      vid_s1_r  <= vid_pin;
      vid_s2_r  <= vid_s1_r;
      vid_d_r   <= vid_s2_r;
      test_s1_r <= test_enable_or_analog_out;
      test_s2_r <= test_s1_r;
      rpin_s1_r <= reset_pin_in;
      rpin_s2_r <= rpin_s1_r;
    end
  end

  // Reset pin state machine.

  rst_pin_state_t rp_r;
  rst_pin_state_t rp_nxt;
  logic [1:0]     blank_r;
  logic           ext_rst;

  // While the pin is ours, or settling after release, its low level is
  // our own pulse and must not reset the block.
  assign ext_rst = (rp_r == RP_IDLE) && !rpin_s2_r;

  always_comb begin
    rp_nxt = rp_r;
    case (rp_r)
      RP_IDLE: begin
        if (tif.start) rp_nxt = RP_DRIVE;
      end
      RP_DRIVE: begin
        if (tif.done) rp_nxt = RP_BLANK;
      end
      RP_BLANK: begin
        if (blank_r == BLANK_CYC - 2'h1) rp_nxt = RP_IDLE;
      end
      default: rp_nxt = RP_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rp_r         <= RP_IDLE;
      blank_r      <= '0;
      reset_pin_oe <= 1'b0;
    end else begin
      rp_r         <= rp_nxt;
      blank_r      <= (rp_r == RP_BLANK) ? blank_r + 2'h1 : '0;
      reset_pin_oe <= (rp_nxt == RP_DRIVE);
    end
  end

  // Open drain: the driven level is always low.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) reset_pin_out <= 1'b0;
    else          reset_pin_out <= 1'b0;
  end

  // Bus slave, zero wait states.

  logic       ap_valid;
  logic       dp_wr_r;
  logic [7:0] dp_addr_r;

  assign ap_valid = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dp_wr_r   <= ap_valid && hwrite;
      dp_addr_r <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  logic wr_cfg;
  logic wr_mode;
  logic wr_status;
  logic wr_mask;

  assign wr_cfg    = dp_wr_r && (dp_addr_r == A_CONFIG);
  assign wr_mode   = dp_wr_r && (dp_addr_r == A_IRQ_MODE);
  assign wr_status = dp_wr_r && (dp_addr_r == A_STATUS);
  assign wr_mask   = dp_wr_r && (dp_addr_r == A_MASK);

  assign tif.start = wr_cfg && hwdata[CFG_PULSE_BIT] &&
                     (rp_r == RP_IDLE) && !tif.busy;

  // Software registers; an outside low on the reset pin restores them all.

  logic [CFG_W-1:0] cfg_r;
  logic [VID_N-1:0] mode_r;
  logic [ST_W-1:0]  mask_r;
  logic [ST_W-1:0]  mask_nxt;
  logic [ST_W-1:0]  status_r;
  logic [ST_W-1:0]  status_nxt;
  logic [ST_W-1:0]  events;
  logic [3:0]       vid_low_r;
  logic             vid4_r;
  logic [3:0]       vid_low_nxt;

  assign mask_nxt = wr_mask ? hwdata[ST_W-1:0] : mask_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r  <= CFG_RST;
      mode_r <= IRQ_MODE_RST;
      mask_r <= MASK_RST;
    end else if (ext_rst) begin
      cfg_r  <= CFG_RST;
      mode_r <= IRQ_MODE_RST;
      mask_r <= MASK_RST;
    end else begin
      if (wr_cfg)  cfg_r  <= hwdata[CFG_W-1:0];
      if (wr_mode) mode_r <= hwdata[VID_N-1:0];
      mask_r <= mask_nxt;
    end
  end

  // Per pin: a falling edge is an interrupt event in interrupt mode;
  // otherwise the level is the voltage-ID bit.
  logic [VID_N-1:0] tree;

  genvar gi;
  generate
    for (gi = 0; gi < VID_N; gi++) begin : g_pin
      assign events[gi] = mode_r[gi] && vid_d_r[gi] && !vid_s2_r[gi];
      if (gi == 0) begin : g_head
        assign tree[gi] = vid_s2_r[gi];
      end else begin : g_link
        assign tree[gi] = !(tree[gi-1] && vid_s2_r[gi]);
      end
      if (gi < 4) begin : g_low
        assign vid_low_nxt[gi] = mode_r[gi] ? vid_low_r[gi]
                                            : vid_s2_r[gi];
      end
    end
  endgenerate

  assign events[EV_PULSE_DONE] = tif.done;

  // A new event beats a clearing write in the same cycle.
  assign status_nxt = (status_r & ~(wr_status ? hwdata[ST_W-1:0] : '0))
                      | events;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_r  <= '0;
      vid_low_r <= '0;
      vid4_r    <= 1'b0;
    end else if (ext_rst) begin
      status_r  <= '0;
      vid_low_r <= '0;
      vid4_r    <= 1'b0;
    end else begin
      status_r  <= status_nxt;
      vid_low_r <= vid_low_nxt;
      if (!mode_r[4]) vid4_r <= vid_s2_r[4];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq <= 1'b0;
    // Built from the next status and mask, so irq tracks the registers.
    else          irq <= !ext_rst && |(status_nxt & mask_nxt);
  end

  // Test-enable pin.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nand_test_mode <= 1'b0;
      analog_out_en  <= 1'b0;
      nand_tree_out  <= 1'b0;
    end else begin
      nand_test_mode <= test_s2_r;
      analog_out_en  <= !test_s2_r;
      nand_tree_out  <= test_s2_r && tree[VID_N-1];
    end
  end

  // Read data is taken in the address phase and stands in the data phase.

  logic [31:0] rd_cfg;
  logic [31:0] rd_pins;
  logic [31:0] rd_val;

  assign rd_cfg = {24'h000000, cfg_r[7:5], rp_r != RP_IDLE, cfg_r[3:0]};
  assign rd_pins = {29'h0, rp_r != RP_IDLE, rpin_s2_r,
                    test_s2_r};

  assign rd_val =
    (haddr[7:0] == A_VID_LOW)  ? {28'h0000000, vid_low_r} :
    (haddr[7:0] == A_VID4)     ? {31'h0, vid4_r} :
    (haddr[7:0] == A_IRQ_MODE) ? {27'h0, mode_r} :
    (haddr[7:0] == A_STATUS)   ? {26'h0, status_r} :
    (haddr[7:0] == A_MASK)     ? {26'h0, mask_r} :
    (haddr[7:0] == A_PINS)     ? rd_pins :
    (haddr[7:0] == A_CONFIG)   ? rd_cfg : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)      hrdata <= '0;
    else if (ap_valid) hrdata <= rd_val;
  end

  // Checks.

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Checks start one edge after reset release, when the capture flops
  // hold pin samples rather than reset values.
  logic live_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) live_r <= 1'b0;
    else          live_r <= 1'b1;
  end

  logic [31:0] oe_len_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)          oe_len_r <= '0;
    else if (reset_pin_oe) oe_len_r <= oe_len_r + 32'h1;
    else                   oe_len_r <= '0;
  end

  property p_test_mode;
    live_r && test_s2_r |=> nand_test_mode && !analog_out_en;
  endproperty
  a_test_mode: assert property (p_test_mode)
    else $error("Test mode not entered.");

  property p_analog_out;
    live_r && !test_s2_r |=>
      analog_out_en && !nand_test_mode && !nand_tree_out;
  endproperty
  a_analog_out: assert property (p_analog_out)
    else $error("Analog output not enabled outside test.");

  property p_pulse_start;
    tif.start |=> reset_pin_oe [*8];
  endproperty
  a_pulse_start: assert property (p_pulse_start)
    else $error("Reset pin not driven after pulse request.");

  property p_pulse_len;
    $fell(reset_pin_oe) |-> $past(oe_len_r) == RST_PULSE_CYC;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("Reset pulse length wrong.");

  property p_ext_rst;
    ext_rst |=> cfg_r == CFG_RST && mask_r == MASK_RST &&
                mode_r == IRQ_MODE_RST && !irq;
  endproperty
  a_ext_rst: assert property (p_ext_rst)
    else $error("Registers not restored by reset pin.");

  property p_self_immune;
    reset_pin_oe |-> !ext_rst;
  endproperty
  a_self_immune: assert property (p_self_immune)
    else $error("Own pulse taken as outside reset.");

  property p_vid4;
    live_r && !mode_r[4] && !ext_rst |=> vid4_r == $past(vid_s2_r[4]);
  endproperty
  a_vid4: assert property (p_vid4)
    else $error("Voltage-ID bit 4 not captured.");

  property p_vid_low;
    live_r && mode_r[3:0] == 4'h0 && !ext_rst |=>
      vid_low_r == $past(vid_s2_r[3:0]);
  endproperty
  a_vid_low: assert property (p_vid_low)
    else $error("Voltage-ID bits 3 to 0 not captured.");

  property p_irq_in;
    events[0] && !ext_rst |=> status_r[0] ##1
      (status_r[0] || $past(wr_status && hwdata[0]) || $past(ext_rst));
  endproperty
  a_irq_in: assert property (p_irq_in)
    else $error("Interrupt input event lost.");

  property p_irq_out;
    |(status_r & mask_r) |-> irq;
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("Interrupt output low with unmasked status.");

  c_pulse: cover property ($fell(reset_pin_oe));
  c_ext:   cover property (ext_rst);
  c_test:  cover property ($rose(nand_test_mode));
  c_irq:   cover property (events[4] ##[1:4] irq);

endmodule

//--- dv/board_model.sv
// Board side of the monitor pins: reset wire, processor VID and test strap.
// Assumes the bench steers the board through its control inputs.
`timescale 1ns/1ps
module board_model (
  input  wire logic       reset_pin_oe,
  input  wire logic       reset_pin_out,
  input  wire logic       ext_rst_low,
  input  wire logic [4:0] vid_code,
  input  wire logic       test_req,
  output logic            reset_pin_in,
  output logic [4:0]      vid_pins,
  output logic            test_pin
);
  logic device_level;

  // The wire has a pull-up, so it rises once nobody pulls it down.
  assign device_level = reset_pin_oe ? reset_pin_out : 1'b1;
  assign reset_pin_in = device_level & ~ext_rst_low;
  assign vid_pins     = vid_code;
  assign test_pin     = test_req;
endmodule

//--- dv/testbench.sv
// Self-checking bench for the monitor pin block over AHB-Lite.
// Assumes the board model drives the reset wire, VID and test pins.
`timescale 1ns/1ps
module testbench;
  import monitor_pins_pkg::*;
  localparam int unsigned RPC = 20;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [31:0] n;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hready;
  logic        hresp;
  logic        analog_out_en;
  logic        nand_test_mode;
  logic        nand_tree_out;
  logic        reset_pin_in;
  logic        reset_pin_out;
  logic        reset_pin_oe;
  logic        irq;
  logic        ext_rst_low;
  logic        test_req;
  logic        test_pin;
  logic [4:0]  vid_code;
  logic [4:0]  vid_pins;
  logic [4:0]  codes [4] = '{5'h15, 5'h0a, 5'h1f, 5'h00};
  int          fail_count = 0;
  int          samples_checked = 0;

  monitor_pins #(.RST_PULSE_CYC(RPC)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .test_enable_or_analog_out(test_pin), .analog_out_en(analog_out_en),
    .nand_test_mode(nand_test_mode), .nand_tree_out(nand_tree_out),
    .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
    .reset_pin_oe(reset_pin_oe),
    .voltage_id_bit4_or_irq(vid_pins[4]),
    .voltage_id_bit3_or_irq(vid_pins[3]),
    .voltage_id_bit2_or_irq(vid_pins[2]),
    .voltage_id_bit1_or_irq(vid_pins[1]),
    .voltage_id_bit0_or_irq(vid_pins[0]), .irq(irq));

  board_model board (
    .reset_pin_oe(reset_pin_oe), .reset_pin_out(reset_pin_out),
    .ext_rst_low(ext_rst_low), .vid_code(vid_code), .test_req(test_req),
    .reset_pin_in(reset_pin_in), .vid_pins(vid_pins), .test_pin(test_pin));

  function automatic logic chain(input logic [4:0] v);
    logic t;
    t = v[0];
    for (int i = 1; i < 5; i++) begin
      t = ~(t & v[i]);
    end
    return t;
  endfunction

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out;
    $display("Checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One single-word transfer; the read data land in rd.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                       input string what);
    xfer(1'b0, a, 32'h0);
    check(what, exp, rd);
    check("hresp", 32'h0, 32'(hresp));
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge hclk);
    @(negedge hclk);
  endtask

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  initial begin
    #(8 * 20000);
    fail_count++;
    close_out;
  end

  initial begin
    hresetn     = 1'b0;
    hsel        = 1'b0;
    haddr       = 32'h0;
    htrans      = 2'b00;
    hwrite      = 1'b0;
    hsize       = 3'h2;
    hwdata      = 32'h0;
    ext_rst_low = 1'b0;
    vid_code    = 5'h1f;
    test_req    = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(4);
    check("reset_pin_oe", 32'h0, 32'(reset_pin_oe));
    check("irq", 32'h0, 32'(irq));
    rdchk(A_CONFIG, 32'h0, "config");
    rdchk(A_MASK, 32'h0, "mask");
    rdchk(A_IRQ_MODE, 32'h0, "irq_mode");
    rdchk(A_PINS, 32'h2, "pins");
    wr(8'h20, 32'hffff_ffff);
    rdchk(8'h20, 32'h0, "unmapped");
    $display("Test defaults done");

    foreach (codes[i]) begin
      @(posedge hclk) vid_code <= codes[i];
      cyc(5);
      rdchk(A_VID_LOW, {28'h0, codes[i][3:0]}, "vid_low");
      rdchk(A_VID4, {31'h0, codes[i][4]}, "vid4");
      @(posedge hclk) test_req <= 1'b1;
      cyc(5);
      check("nand_test_mode", 32'h1, 32'(nand_test_mode));
      check("nand_tree_out", 32'(chain(codes[i])), 32'(nand_tree_out));
      check("analog_out_en", 32'h0, 32'(analog_out_en));
      @(posedge hclk) test_req <= 1'b0;
      cyc(5);
      check("analog_out_en", 32'h1, 32'(analog_out_en));
      check("nand_test_mode", 32'h0, 32'(nand_test_mode));
      check("nand_tree_out", 32'h0, 32'(nand_tree_out));
    end
    $display("Test vid and nand tree done");

    wr(A_MASK, 32'h20);
    wr(A_CONFIG, 32'h10);
    @(negedge hclk);
    check("reset_pin_in", 32'h0, 32'(reset_pin_in));
    check("reset_pin_out", 32'h0, 32'(reset_pin_out));
    n = 32'h0;
    while (reset_pin_oe === 1'b1) begin
      n++;
      @(negedge hclk);
    end
    check("pulse_cycles", RPC + 1, n);
    cyc(5);
    check("irq", 32'h1, 32'(irq));
    rdchk(A_CONFIG, 32'h0, "config");
    rdchk(A_STATUS, 32'h20, "status");
    rdchk(A_MASK, 32'h20, "mask");
    wr(A_STATUS, 32'h20);
    cyc(2);
    check("irq", 32'h0, 32'(irq));
    $display("Test reset pulse done");

    @(posedge hclk) vid_code <= 5'h1f;
    wr(A_IRQ_MODE, 32'h1f);
    wr(A_MASK, 32'h1f);
    for (int i = 0; i < 5; i++) begin
      @(posedge hclk) vid_code <= 5'h1f ^ (5'h1 << i);
      cyc(6);
      check("irq", 32'h1, 32'(irq));
      rdchk(A_STATUS, 32'h1 << i, "status");
      @(posedge hclk) vid_code <= 5'h1f;
      wr(A_STATUS, 32'h1 << i);
      cyc(2);
      check("irq", 32'h0, 32'(irq));
    end
    wr(A_MASK, 32'h0);
    @(posedge hclk) vid_code <= 5'h1b;
    cyc(6);
    check("irq", 32'h0, 32'(irq));
    rdchk(A_STATUS, 32'h4, "status");
    $display("Test interrupts done");

    wr(A_MASK, 32'h3f);
    wr(A_CONFIG, 32'ha5);
    @(posedge hclk) ext_rst_low <= 1'b1;
    cyc(6);
    @(posedge hclk) ext_rst_low <= 1'b0;
    cyc(6);
    check("irq", 32'h0, 32'(irq));
    rdchk(A_CONFIG, 32'h0, "config");
    rdchk(A_MASK, 32'h0, "mask");
    rdchk(A_IRQ_MODE, 32'h0, "irq_mode");
    rdchk(A_STATUS, 32'h0, "status");
    $display("Test external reset done");
    close_out;
  end
endmodule
